// [hw/uds_top.sv]
// Up/down speed reference, three-wire latch and dwell sequencing
`include "uds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module uds_top
  import uds_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Terminals and their function codes
  input wire logic [7:0] termIn,
  input wire logic [39:0] termFunc,
  input wire logic runStart,
  input wire logic stopCmd,
  // Configuration
  input wire logic [3:0] freqSrcSel,
  input wire logic [1:0] updownModeSel,
  input wire logic [15:0] updownStepFreq,
  input wire logic updownSaveSel,
  input wire logic [15:0] accelRate,
  input wire uds_limits_type limits,
  input wire logic [15:0] dwellFreq,
  input wire logic [6:0] dwellTime,
  // Results
  output logic [15:0] freqRef,
  output logic [15:0] updownSavedFreq,
  output logic runLatched,
  output logic dwellActive,
  output logic modeErr
);
  // ==========================================
  // Terminal decode
  function automatic logic anyFunc(input logic [7:0] t, input logic [39:0] f,
                                   input logic [4:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (f[i*5 +: 5] == code && t[i]) r = 1'b1;
    end
    return r;
  endfunction
  function automatic logic isAssigned(input logic [39:0] f, input logic [4:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (f[i*5 +: 5] == code) r = 1'b1;
    end
    return r;
  endfunction
  logic upIn, downIn, initIn, wireIn, udOn, udAssigned;
  always_comb begin
    upIn = anyFunc(termIn, termFunc, `UDS_FN_UP);
    downIn = anyFunc(termIn, termFunc, `UDS_FN_DOWN);
    initIn = anyFunc(termIn, termFunc, `UDS_FN_SAVE_INIT);
    wireIn = anyFunc(termIn, termFunc, `UDS_FN_3WIRE);
    udAssigned = isAssigned(termFunc, `UDS_FN_UP) | isAssigned(termFunc, `UDS_FN_DOWN);
    udOn = (freqSrcSel == `UDS_FRQ_UPDOWN);
  end
  logic upD_reg, downD_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upD_reg <= 1'b0;
      downD_reg <= 1'b0;
    end else begin
      upD_reg <= upIn;
      downD_reg <= downIn;
    end
  end
  logic upRise, downRise, upFall, downFall;
  always_comb begin
    upRise = upIn & ~upD_reg;
    downRise = downIn & ~downD_reg;
    upFall = ~upIn & upD_reg;
    downFall = ~downIn & downD_reg;
  end
  // ==========================================
  // Three-wire run latch
  // Pulse width is the driver's duty; a one-cycle start is latched if stop is low and the three-wire terminal is on or unassigned
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runLatched <= 1'b0;
    end else if (stopCmd) begin
      runLatched <= 1'b0;
    end else if (runStart && (wireIn || !isAssigned(termFunc, `UDS_FN_3WIRE))) begin
      runLatched <= 1'b1;
    end
  end
  // ==========================================
  // Rate tick and hold timer
  logic [9:0] tickCnt_reg;
  logic tick;
  always_ff @(posedge clk) begin
    if (!rst_n || tickCnt_reg == 10'(`UDS_TICK_CYC - 1)) begin
      tickCnt_reg <= 10'h000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 10'h001;
    end
  end
  assign tick = (tickCnt_reg == 10'(`UDS_TICK_CYC - 1));
  logic [28:0] holdCnt_reg;
  logic holdDone;
  always_ff @(posedge clk) begin
    if (!rst_n || !(upIn ^ downIn)) begin
      holdCnt_reg <= 29'h00000000;
    end else if (!holdDone) begin
      holdCnt_reg <= holdCnt_reg + 29'h00000001;
    end
  end
  assign holdDone = (holdCnt_reg >= 29'(`UDS_HOLD_CYC));
  // ==========================================
  // Target computation
  logic [15:0] target_reg, hiLim, loLim;
  logic settled, contUp, contDown, stepOk;
  logic [1:0] mode;
  logic [15:0] rampOut;
  always_comb begin
    hiLim = (limits.limitEn && limits.upperLim < limits.maxFreq) ? limits.upperLim
                                                                 : limits.maxFreq;
    loLim = limits.limitEn ? limits.lowerLim : 16'h0000;
    mode = (updownModeSel > `UDS_MODE_COMB) ? `UDS_MODE_CONT : updownModeSel;
    contUp = upIn & ((mode == `UDS_MODE_CONT) | ((mode == `UDS_MODE_COMB) & holdDone));
    contDown = downIn & ((mode == `UDS_MODE_CONT) | ((mode == `UDS_MODE_COMB) & holdDone));
    stepOk = (mode != `UDS_MODE_CONT) & settled;
  end
  function automatic logic [15:0] clampAdd(input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] hi);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, hi}) ? hi : s[15:0];
  endfunction
  function automatic logic [15:0] clampSub(input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] lo);
    // Compare in 17 bits so a large lower limit plus step cannot wrap
    return ({1'b0, a} < ({1'b0, lo} + {1'b0, b})) ? lo : a - b;
  endfunction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      target_reg <= 16'h0000;
    end else if (!udOn) begin
      target_reg <= target_reg;
    end else if (contUp) begin
      target_reg <= hiLim;
    end else if (contDown) begin
      target_reg <= loLim;
    end else if (upRise && stepOk) begin
      target_reg <= clampAdd(rampOut, updownStepFreq, hiLim);
    end else if (downRise && stepOk) begin
      target_reg <= clampSub(rampOut, updownStepFreq, loLim);
    end else if ((upFall || downFall) && (mode != `UDS_MODE_STEP)) begin
      target_reg <= rampOut; // Continuous phase ends where the ramp stands
    end
  end
  uds_ramp rampInst (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .rate(accelRate),
    .target(target_reg),
    .freqOut(rampOut),
    .settled(settled)
  );
  // ==========================================
  // Saved frequency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      updownSavedFreq <= 16'h0000;
    end else if (initIn && !(upIn || downIn)) begin
      updownSavedFreq <= 16'h0000;
    end else if (updownSaveSel && udAssigned && (upFall || downFall)) begin
      updownSavedFreq <= rampOut;
    end else if (updownSaveSel && !udAssigned && stopCmd && runLatched) begin
      updownSavedFreq <= updownSavedFreq;
    end
  end
  // ==========================================
  // Dwell sequence
  uds_dwell_type dState_reg;
  logic [6:0] dCnt_reg;
  logic [23:0] dTick_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dState_reg <= DWELL_IDLE;
      dCnt_reg <= 7'h00;
      dTick_reg <= 24'h000000;
    end else if (!runLatched) begin
      dState_reg <= DWELL_IDLE;
    end else begin
      unique case (dState_reg)
        DWELL_IDLE: begin
          dCnt_reg <= 7'h00;
          dTick_reg <= 24'h000000;
          dState_reg <= (dwellTime == 7'h00) ? DWELL_RUN : DWELL_HOLD;
        end
        DWELL_HOLD: begin
          if (dTick_reg == 24'(`UDS_DWELL_TICK_CYC - 1)) begin
            dTick_reg <= 24'h000000;
            dCnt_reg <= dCnt_reg + 7'h01;
            if (dCnt_reg + 7'h01 >= dwellTime) dState_reg <= DWELL_RUN;
          end else begin
            dTick_reg <= dTick_reg + 24'h000001;
          end
        end
        DWELL_RUN: dState_reg <= DWELL_RUN;
      endcase
    end
  end
  // ==========================================
  // Outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freqRef <= 16'h0000;
      dwellActive <= 1'b0;
      modeErr <= 1'b0;
    end else begin
      dwellActive <= (dState_reg == DWELL_HOLD);
      freqRef <= !runLatched ? 16'h0000 :
                 (dState_reg != DWELL_RUN) ? dwellFreq : rampOut;
      modeErr <= (updownModeSel > `UDS_MODE_COMB);
    end
  end
endmodule
`default_nettype wire

// [inc/uds_cfg.svh]
// Constants for the up/down speed reference block
`ifndef UDS_CFG_SVH
`define UDS_CFG_SVH
`define UDS_CLK_HZ 100000000
`define UDS_FW 16
`define UDS_MODE_CONT 2'h0
`define UDS_MODE_STEP 2'h1
`define UDS_MODE_COMB 2'h2
`define UDS_FN_UP 5'h0F
`define UDS_FN_DOWN 5'h10
`define UDS_FN_3WIRE 5'h11
`define UDS_FN_SAVE_INIT 5'h19
`define UDS_FRQ_UPDOWN 4'h8
`define UDS_HOLD_MS 3000
`define UDS_HOLD_CYC (`UDS_HOLD_MS * (`UDS_CLK_HZ / 1000))
`define UDS_TICK_US 10
`define UDS_TICK_CYC (`UDS_TICK_US * (`UDS_CLK_HZ / 1000000))
`define UDS_DWELL_FREQ_RST 16'h01F4
`define UDS_DWELL_TICK_MS 100
`define UDS_DWELL_TICK_CYC (`UDS_DWELL_TICK_MS * (`UDS_CLK_HZ / 1000))
`endif

// [inc/uds_pkg.sv]
// Types for the up/down speed reference block
package uds_pkg;
  typedef struct packed {
    logic [15:0] maxFreq;
    logic [15:0] upperLim;
    logic [15:0] lowerLim;
    logic limitEn;
  } uds_limits_type;
  typedef enum logic [1:0] {DWELL_IDLE, DWELL_HOLD, DWELL_RUN} uds_dwell_type;
endpackage

// [hw/uds_ramp.sv]
// Rate limited ramp of the output reference toward a target
`timescale 1ns/1ps
`default_nettype none
module uds_ramp
  import uds_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic [15:0] rate,
  input wire logic [15:0] target,
  // Result
  output logic [15:0] freqOut,
  output logic settled
);
  logic [16:0] diff;
  always_comb begin
    diff = {1'b0, target} - {1'b0, freqOut};
  end
  // Both step and continuous changes share the same rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freqOut <= 16'h0000;
    end else if (tick) begin
      if (target > freqOut) begin
        freqOut <= (diff[15:0] > rate) ? freqOut + rate : target;
      end else if (target < freqOut) begin
        freqOut <= ((freqOut - target) > rate) ? freqOut - rate : target;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settled <= 1'b1;
    end else begin
      settled <= (target == freqOut);
    end
  end
endmodule
`default_nettype wire

// [test/uds_top_props.sv]
// Port checker for the up/down speed reference
`timescale 1ns/1ps
`default_nettype none
module uds_top_props
  import uds_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input wire logic runStart,
  input wire logic stopCmd,
  input wire logic [7:0] termIn,
  input wire logic [1:0] updownModeSel,
  input wire logic [15:0] accelRate,
  input wire uds_limits_type limits,
  input wire logic [15:0] dwellFreq,
  input wire logic [6:0] dwellTime,
  // Outputs watched
  input wire logic [15:0] freqRef,
  input wire logic [15:0] updownSavedFreq,
  input wire logic runLatched,
  input wire logic dwellActive,
  input wire logic modeErr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  mode_err_a: assert property (1'b1 |=> modeErr == ($past(updownModeSel) == 2'h3))
    else $error("mode error flag wrong");
  run_hold_a: assert property (runLatched && !stopCmd |=> runLatched)
    else $error("run latch dropped");
  stop_clear_a: assert property (stopCmd |=> !runLatched)
    else $error("stop did not clear run");
  run_cause_a: assert property ($rose(runLatched) |-> $past(runStart))
    else $error("run latched without start");
  dwell_freq_a: assert property (dwellActive && runLatched |-> freqRef == dwellFreq)
    else $error("dwell frequency wrong");
  dwell_start_a: assert property ($rose(runLatched) && dwellTime != 7'h0 |-> ##[1:3] dwellActive)
    else $error("dwell not entered");
  upper_bound_a: assert property (limits.limitEn && runLatched && !dwellActive
    |-> freqRef <= limits.upperLim)
    else $error("reference above upper limit");
  ramp_rate_a: assert property (runLatched && $past(runLatched) && !$past(dwellActive)
    && !$past(dwellActive, 2) |-> (freqRef > $past(freqRef) ? freqRef - $past(freqRef)
    : $past(freqRef) - freqRef) <= accelRate)
    else $error("reference moved faster than rate");
  save_edge_a: assert property ($changed(updownSavedFreq) |-> $past(termIn) != $past(termIn, 2)
    || $past(termIn, 2) != $past(termIn, 3))
    else $error("saved value changed without edge");
endmodule
bind uds_top uds_top_props u_props (.clk, .rst_n, .runStart, .stopCmd, .termIn,
  .updownModeSel, .accelRate, .limits, .dwellFreq, .dwellTime, .freqRef,
  .updownSavedFreq, .runLatched, .dwellActive, .modeErr);
`default_nettype wire

// [test/uds_buttons.sv]
// Push-button model in front of the input terminals
`timescale 1ns/1ps
`default_nettype none
module uds_buttons #(parameter int HOLD = 5) (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic startReq,
  input wire logic [7:0] pressIn,
  // Terminal side
  output logic [7:0] termIn,
  output logic runStart
);
  int cnt = 0;
  // Short hold stands in for the minimum pulse width to keep runs brief
  always_ff @(posedge clk) begin
    if (startReq) begin
      cnt <= HOLD;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign runStart = cnt != 0;
  assign termIn = pressIn;
endmodule
`default_nettype wire

// [test/uds_top_tb.sv]
// Self-checking bench of the up/down speed reference
`include "uds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module uds_top_tb
  import uds_pkg::*;
;
  logic clk = 0, rst_n = 0, startReq = 0, stopCmd = 0, updownSaveSel = 1;
  logic [7:0] pressIn = 8'h08;
  logic [39:0] termFunc;
  logic [3:0] freqSrcSel = 4'h8;
  logic [1:0] updownModeSel = 2'h0;
  logic [15:0] updownStepFreq, accelRate, dwellFreq = 16'h0010, s, hi;
  logic [6:0] dwellTime = 7'h0;
  uds_limits_type limits;
  wire logic [7:0] termIn;
  wire logic runStart, runLatched, dwellActive, modeErr;
  wire logic [15:0] freqRef, updownSavedFreq;
  int num_errors = 0, tests_run = 0, cycles = 0;
  uds_buttons btn (.clk, .startReq, .pressIn, .termIn, .runStart);
  uds_top dut (.clk, .rst_n, .termIn, .termFunc, .runStart, .stopCmd, .freqSrcSel,
    .updownModeSel, .updownStepFreq, .updownSaveSel, .accelRate, .limits, .dwellFreq,
    .dwellTime, .freqRef, .updownSavedFreq, .runLatched, .dwellActive, .modeErr);
  function automatic logic [15:0] nxt(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // Holding until the ramp settles makes the saved value well defined
  task automatic press(input int b);
    pressIn[b] = 1;
    cyc(3000);
    pressIn[b] = 0;
    cyc(5);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    s = (nxt(16'h001B) & 16'h0F00) | 16'h0100;
    hi = s * 2 + (s >> 1);
    updownStepFreq = s;
    accelRate = s >> 1;
    limits = '{16'hFFFF, hi, s >> 1, 1'b1};
    termFunc = {20'h0, `UDS_FN_3WIRE, `UDS_FN_SAVE_INIT, `UDS_FN_DOWN, `UDS_FN_UP};
    cyc(2);
    rst_n = 1;
    cyc(2);
    chk("freqRef", 16'h0, freqRef);
    for (int m = 0; m < 4; m++) begin
      updownModeSel = m[1:0];
      cyc(2);
      chk("modeErr", {15'h0, m == 3}, {15'h0, modeErr});
    end
    updownModeSel = `UDS_MODE_STEP;
    startReq = 1;
    cyc(1);
    startReq = 0;
    cyc(3000);
    chk("runLatched", 16'h1, {15'h0, runLatched});
    press(0);
    chk("freqRef", s, freqRef);
    chk("saved", s, updownSavedFreq);
    pressIn[0] = 1;
    cyc(2);
    pressIn[0] = 0;
    cyc(4);
    press(0);
    chk("freqRef", s * 2, freqRef);
    press(0);
    chk("freqRef", hi, freqRef);
    pressIn[0] = 1;
    pressIn[2] = 1;
    cyc(2);
    pressIn[2] = 0;
    cyc(2);
    chk("saved", hi, updownSavedFreq);
    pressIn[0] = 0;
    cyc(5);
    pressIn[2] = 1;
    cyc(2);
    pressIn[2] = 0;
    cyc(3);
    chk("saved", 16'h0, updownSavedFreq);
    press(1);
    chk("freqRef", hi - s, freqRef);
    updownModeSel = `UDS_MODE_CONT;
    pressIn[1] = 1;
    cyc(6000);
    pressIn[1] = 0;
    cyc(5);
    chk("freqRef", s >> 1, freqRef);
    pressIn[0] = 1;
    cyc(6000);
    pressIn[0] = 0;
    cyc(5);
    chk("freqRef", hi, freqRef);
    updownModeSel = `UDS_MODE_COMB;
    updownSaveSel = 0;
    press(1);
    chk("freqRef", hi - s, freqRef);
    chk("saved", hi, updownSavedFreq);
    updownSaveSel = 1;
    freqSrcSel = 4'h4;
    press(0);
    chk("freqRef", hi - s, freqRef);
    freqSrcSel = `UDS_FRQ_UPDOWN;
    stopCmd = 1;
    cyc(3);
    stopCmd = 0;
    chk("runLatched", 16'h0, {15'h0, runLatched});
    chk("saved", hi - s, updownSavedFreq);
    dwellTime = 7'h1;
    startReq = 1;
    cyc(1);
    startReq = 0;
    cyc(6);
    chk("dwellActive", 16'h1, {15'h0, dwellActive});
    chk("freqRef", dwellFreq, freqRef);
    summarize();
  end
endmodule
`default_nettype wire
